// *** tc_strap_status.sv ***
// Purpose: static straps, buffer selects and status pins of the decoder
// Assumes: one 250 MHz clock, asynchronous active-low reset, APB slave
// Notes:   straps are sampled once after reset or on software request
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tc_strap_params.svh"

module tc_strap_status
	import tc_strap_pkg::*;
#(
	parameter int VCID_W = 6
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n_a,
	// apb slave
	input  wire apb_req_t          i_apb,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// asynchronous strap pins
	input  wire logic              i_external_auth_sel,
	input  wire logic              i_auth_tail_len_sel,
	input  wire logic              i_vchan_id_lsb_invert,
	input  wire logic              i_telemetry_sample_style,
	input  wire logic              i_parallel_sel,
	input  wire logic              i_priority_sel,
	input  wire logic              i_mode_reserved,
	input  wire logic              i_test_mode,
	input  wire logic              i_phys_layer_flag_n,
	// events from the decoder core, same clock
	input  wire logic              i_aus_swap,
	input  wire logic              i_far_swap,
	input  wire logic              i_frame_stored,
	input  wire logic [2:0]        i_frame_chan,
	input  wire logic              i_start_found,
	input  wire logic              i_tail_end,
	input  wire logic [VCID_W-1:0] i_rom_vcid,
	// status and configuration outputs
	output logic                   o_auth_status_buf_sel,
	output logic                   o_accept_report_buf_sel,
	output logic [2:0]             o_last_input_channel,
	output logic                   o_decoding_active,
	output logic                   o_link_word_flag,
	output logic                   o_use_ext_auth,
	output logic [3:0]             o_auth_tail_octets,
	output logic                   o_lac_in_ram,
	output logic [2:0]             o_tm_samples,
	output logic                   o_parallel_mode,
	output logic                   o_priority_mode,
	output logic [VCID_W-1:0]      o_vcid,
	output logic                   o_cfg_valid
);

	// ****************************************************************
	// synchronisers
	// ****************************************************************
	logic [8:0]  sync1_q;
	logic [8:0]  sync2_q;
	logic [8:0]  pins;

	// low six bits line up with strap_cfg_t, external select on top
	assign pins = {i_test_mode, i_mode_reserved, i_phys_layer_flag_n,
		i_external_auth_sel, i_auth_tail_len_sel,
		i_vchan_id_lsb_invert, i_telemetry_sample_style,
		i_parallel_sel, i_priority_sel};

	// two stages; only the second is read anywhere
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			sync1_q <= `SYNC_RST;
			sync2_q <= `SYNC_RST;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end

	// ****************************************************************
	// strap capture
	// ****************************************************************
	cap_state_t  cap_q;
	logic [1:0]  settle_q;
	strap_cfg_t  cfg_q;
	logic        resample_q;
	logic        fault_clr_q;

	// wait for the synchronisers to fill before trusting the straps
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			cap_q    <= CAP_SETTLE;
			settle_q <= 2'h0;
		end else begin
			case (cap_q)
				CAP_SETTLE: begin
					if (settle_q == `STRAP_SETTLE_CYC) begin
						cap_q <= CAP_TAKE;
					end else begin
						settle_q <= settle_q + 2'h1;
					end
				end
				CAP_TAKE: begin
					cap_q <= CAP_HOLD;
				end
				CAP_HOLD: begin
					// straps are static; software may ask for a fresh look
					if (resample_q) begin
						cap_q <= CAP_TAKE;
					end
				end
				default: begin
					cap_q <= CAP_SETTLE;
				end
			endcase
		end
	end

	// configuration is frozen outside the take state
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			cfg_q       <= '0;
			o_cfg_valid <= 1'b0;
		end else if (cap_q == CAP_TAKE) begin
			cfg_q       <= strap_cfg_t'(sync2_q[5:0]);
			o_cfg_valid <= 1'b1;
		end
	end

	// ****************************************************************
	// derived configuration outputs
	// ****************************************************************
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			o_use_ext_auth     <= 1'b0;
			o_auth_tail_octets <= `AUTH_TAIL_NONE;
			o_lac_in_ram       <= 1'b0;
			o_tm_samples       <= `TM_SAMPLES_LOW;
			o_parallel_mode    <= 1'b0;
			o_priority_mode    <= 1'b0;
		end else begin
			o_use_ext_auth <= cfg_q.ext_auth;
			// tail select sets o_auth_tail_octets on the external path, o_lac_in_ram otherwise
			if (cfg_q.ext_auth) begin
				o_auth_tail_octets <= cfg_q.tail_len_sel ?
					`AUTH_TAIL_NONE : `AUTH_TAIL_EXT;
				o_lac_in_ram       <= 1'b0;
			end else begin
				o_auth_tail_octets <= `AUTH_TAIL_NONE;
				o_lac_in_ram       <= cfg_q.tail_len_sel;
			end
			o_tm_samples    <= cfg_q.tm_style ?
				`TM_SAMPLES_HIGH : `TM_SAMPLES_LOW;
			o_parallel_mode <= cfg_q.parallel;
			o_priority_mode <= cfg_q.prior;
		end
	end

	// channel identity; redundant decoder shares the rom
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			o_vcid <= '0;
		end else begin
			o_vcid <= i_rom_vcid ^ {{(VCID_W-1){1'b0}},
				cfg_q.vcid_inv};
		end
	end

	// ****************************************************************
	// buffer selects and channel report
	// ****************************************************************
	// each swap hands the other buffer to the external unit
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			o_auth_status_buf_sel   <= 1'b0;
			o_accept_report_buf_sel <= 1'b0;
		end else begin
			if (i_aus_swap) begin
				o_auth_status_buf_sel <= ~o_auth_status_buf_sel;
			end
			if (i_far_swap) begin
				o_accept_report_buf_sel <= ~o_accept_report_buf_sel;
			end
		end
	end

	// updated only when a frame lands in the back-end buffer
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			o_last_input_channel <= 3'h0;
		end else if (i_frame_stored) begin
			o_last_input_channel <= i_frame_chan;
		end
	end

	// ****************************************************************
	// decode state and link flag
	// ****************************************************************
	// start wins over tail end so a back-to-back start is not lost
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			o_decoding_active <= 1'b0;
		end else if (i_start_found) begin
			o_decoding_active <= 1'b1;
		end else if (i_tail_end) begin
			o_decoding_active <= 1'b0;
		end
	end

	// active-high copy for the link control word builder
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			o_link_word_flag <= 1'b0;
		end else begin
			o_link_word_flag <= ~sync2_q[6];
		end
	end

	// ****************************************************************
	// reserved pin watch
	// ****************************************************************
	logic strap_fault_q;

	// a board that breaks the ground ties is flagged; set beats clear
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			strap_fault_q <= 1'b0;
		end else if (sync2_q[7] || sync2_q[8]) begin
			strap_fault_q <= 1'b1;
		end else if (fault_clr_q) begin
			strap_fault_q <= 1'b0;
		end
	end

	// ****************************************************************
	// apb slave
	// ****************************************************************
	logic access;
	logic done;

	assign access = i_apb.psel && i_apb.penable;
	assign done   = access && o_pready;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `REG_CTRL) || (a == `REG_CONFIG) ||
			(a == `REG_STATUS);
	endfunction : mapped

	function automatic logic [31:0] read_word(input logic [11:0] a);
		read_word = 32'h0000_0000;
		case (a)
			`REG_CONFIG: begin
				read_word = {16'h0000, 1'b0, o_tm_samples,
					o_auth_tail_octets, 2'b00, cfg_q};
			end
			`REG_STATUS: begin
				read_word = {22'h00_0000, o_cfg_valid, strap_fault_q,
					o_lac_in_ram, o_link_word_flag,
					o_decoding_active, o_last_input_channel,
					o_accept_report_buf_sel, o_auth_status_buf_sel};
			end
			default: begin
				read_word = 32'h0000_0000;
			end
		endcase
	endfunction : read_word

	// one wait state: pready rises the cycle after the access phase starts
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (access && !o_pready) begin
			o_pready  <= 1'b1;
			o_pslverr <= !mapped(i_apb.paddr);
			o_prdata  <= i_apb.pwrite ? 32'h0000_0000 :
				read_word(i_apb.paddr);
		end else begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end
	end

	// writes act only at the completing edge
	always_ff @(posedge i_clk_sys or negedge i_reset_n_a) begin
		if (!i_reset_n_a) begin
			resample_q  <= 1'b0;
			fault_clr_q <= 1'b0;
		end else begin
			resample_q  <= 1'b0;
			fault_clr_q <= 1'b0;
			if (done && i_apb.pwrite && i_apb.paddr == `REG_CTRL) begin
				resample_q  <= i_apb.pwdata[`CTRL_RESAMPLE_BIT];
				fault_clr_q <= i_apb.pwdata[`CTRL_FAULT_CLR];
			end
		end
	end

endmodule : tc_strap_status

// *** tc_strap_params.svh ***
// Purpose: constants for the decoder strap and status block
// Assumes: included by bare name from the design only
// Notes:   offsets are byte addresses on the register bus
`ifndef TC_STRAP_PARAMS_SVH
`define TC_STRAP_PARAMS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define REG_CTRL          12'h000
`define REG_CONFIG        12'h004
`define REG_STATUS        12'h008

// ctrl bits (write side)
`define CTRL_RESAMPLE_BIT 0
`define CTRL_FAULT_CLR    1

// ****************************************************************
// strap meanings and timing
// ****************************************************************
`define AUTH_TAIL_EXT     4'h9
`define AUTH_TAIL_NONE    4'h0
`define TM_SAMPLES_LOW    3'h5
`define TM_SAMPLES_HIGH   3'h2
`define STRAP_SETTLE_CYC  2'h3
// sync vector reset: straps low, physical layer flag inactive high
`define SYNC_RST          9'h040

`endif

// *** tc_strap_pkg.sv ***
// Purpose: types shared by the strap and status block
// Assumes: tc_strap_params.svh holds the numbers
// Notes:   structs carry groups of related pins
package tc_strap_pkg;
	// captured static configuration
	typedef struct packed {
		logic ext_auth;
		logic tail_len_sel;
		logic vcid_inv;
		logic tm_style;
		logic parallel;
		logic prior;
	} strap_cfg_t;

	// apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// capture sequencer
	typedef enum logic [1:0] {
		CAP_SETTLE,
		CAP_TAKE,
		CAP_HOLD
	} cap_state_t;
endpackage : tc_strap_pkg

// *** tc_strap_checker_assertions.sv ***
// Purpose: port assertions for the strap and status block
// Assumes: one clock, asynchronous active-low reset
// Notes:   event outputs follow their pulse by one edge
`timescale 1ns/1ps
module tc_strap_checker
	import tc_strap_pkg::*;
#(
	parameter int VCID_W = 6
) (
	input wire logic              i_clk_sys,
	input wire logic              i_reset_n_a,
	input wire apb_req_t          i_apb,
	input wire logic              o_pready,
	input wire logic              o_pslverr,
	input wire logic              i_phys_layer_flag_n,
	input wire logic              i_aus_swap,
	input wire logic              i_far_swap,
	input wire logic              i_frame_stored,
	input wire logic [2:0]        i_frame_chan,
	input wire logic              i_start_found,
	input wire logic              i_tail_end,
	input wire logic [VCID_W-1:0] i_rom_vcid,
	input wire logic              o_auth_status_buf_sel,
	input wire logic              o_accept_report_buf_sel,
	input wire logic [2:0]        o_last_input_channel,
	input wire logic              o_decoding_active,
	input wire logic              o_link_word_flag,
	input wire logic              o_use_ext_auth,
	input wire logic [3:0]        o_auth_tail_octets,
	input wire logic              o_lac_in_ram,
	input wire logic [VCID_W-1:0] o_vcid,
	input wire logic              o_cfg_valid
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n_a);

	a_aus_toggle: assert property (i_aus_swap |=>
		o_auth_status_buf_sel != $past(o_auth_status_buf_sel))
		else $error("aus select");
	a_far_toggle: assert property (i_far_swap |=>
		o_accept_report_buf_sel != $past(o_accept_report_buf_sel))
		else $error("far select");
	a_chan_take: assert property (i_frame_stored |=>
		o_last_input_channel == $past(i_frame_chan))
		else $error("chan taken");
	a_chan_hold: assert property (!i_frame_stored |=>
		$stable(o_last_input_channel)) else $error("chan moved");
	a_decode_set: assert property (i_start_found |=>
		o_decoding_active) else $error("decode set");
	a_decode_clr: assert property (i_tail_end && !i_start_found |=>
		!o_decoding_active) else $error("decode clear");
	a_flag_low: assert property (!i_phys_layer_flag_n [*4] |->
		o_link_word_flag) else $error("flag low");
	a_flag_high: assert property (i_phys_layer_flag_n [*4] |->
		!o_link_word_flag) else $error("flag high");
	a_auth_split: assert property (!o_use_ext_auth |->
		o_auth_tail_octets == 4'h0) else $error("tail internal");
	a_lac_ext: assert property (o_use_ext_auth |-> !o_lac_in_ram)
		else $error("lac external");
	a_vcid_high: assert property (o_cfg_valid && $past(o_cfg_valid) |->
		o_vcid[VCID_W-1:1] == $past(i_rom_vcid[VCID_W-1:1]))
		else $error("vcid");
	a_ready_wait: assert property (i_apb.psel && i_apb.penable && !o_pready
		|=> o_pready) else $error("apb answer");
	a_err_ready: assert property (o_pslverr |-> o_pready) else $error("slverr");
endmodule : tc_strap_checker

bind tc_strap_status tc_strap_checker #(.VCID_W(VCID_W)) chk_i (
	.i_clk_sys(i_clk_sys), .i_reset_n_a(i_reset_n_a), .i_apb(i_apb),
	.o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_phys_layer_flag_n(i_phys_layer_flag_n), .i_aus_swap(i_aus_swap),
	.i_far_swap(i_far_swap), .i_frame_stored(i_frame_stored),
	.i_frame_chan(i_frame_chan), .i_start_found(i_start_found),
	.i_tail_end(i_tail_end), .i_rom_vcid(i_rom_vcid),
	.o_auth_status_buf_sel(o_auth_status_buf_sel),
	.o_accept_report_buf_sel(o_accept_report_buf_sel),
	.o_last_input_channel(o_last_input_channel),
	.o_decoding_active(o_decoding_active),
	.o_link_word_flag(o_link_word_flag), .o_use_ext_auth(o_use_ext_auth),
	.o_auth_tail_octets(o_auth_tail_octets), .o_lac_in_ram(o_lac_in_ram),
	.o_vcid(o_vcid), .o_cfg_valid(o_cfg_valid));

// *** tc_strap_board.sv ***
// Purpose: board model driving the strap pins and link flag
// Assumes: settings come from the bench on the system clock
// Notes:   pins order {mode,test,ext,tail,vcinv,tm,par,prior,flag_n}
`timescale 1ns/1ps
module tc_strap_board (
	input  wire logic       i_clk_sys,
	input  wire logic [6:0] i_set,
	output logic [8:0]      o_pins
);
	// reserved and test pins tied low; straps only move on request
	always_ff @(posedge i_clk_sys) begin
		o_pins <= {2'b00, i_set};
	end
endmodule : tc_strap_board

// *** tc_strap_status_tb.sv ***
// Purpose: self-checking bench for the strap and status block
// Assumes: board model drives straps, bench drives core events
// Notes:   bus master waits on pready, never on a fixed count
`timescale 1ns/1ps
module tc_strap_status_tb;
	import tc_strap_pkg::*;
	logic clk = 0, rst_n = 0, aus_sw, far_sw, stored, start, tail_end;
	logic pready, pslverr, aus_sel, far_sel, dec, lflag, ext, logical_auth_counter, par, pri;
	logic cvalid, e, m_aus, m_far, m_dec;
	logic [2:0] chan, lchan, tms, m_chan;
	logic [3:0] oct;
	logic [5:0] rom, vcid, cfg, m_vc;
	logic [6:0] brd;
	logic [8:0] pins;
	logic [13:0] pv;
	logic [31:0] prdata, r;
	apb_req_t apb;
	int err_total, samples_checked, i;

	tc_strap_board brd_i (.i_clk_sys(clk), .i_set(brd), .o_pins(pins));
	tc_strap_status uut (.i_clk_sys(clk), .i_reset_n_a(rst_n), .i_apb(apb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_external_auth_sel(pins[6]), .i_auth_tail_len_sel(pins[5]),
		.i_vchan_id_lsb_invert(pins[4]), .i_telemetry_sample_style(pins[3]),
		.i_parallel_sel(pins[2]), .i_priority_sel(pins[1]),
		.i_mode_reserved(pins[8]), .i_test_mode(pins[7]),
		.i_phys_layer_flag_n(pins[0]), .i_aus_swap(aus_sw),
		.i_far_swap(far_sw), .i_frame_stored(stored), .i_frame_chan(chan),
		.i_start_found(start), .i_tail_end(tail_end), .i_rom_vcid(rom),
		.o_auth_status_buf_sel(aus_sel), .o_accept_report_buf_sel(far_sel),
		.o_last_input_channel(lchan), .o_decoding_active(dec),
		.o_link_word_flag(lflag), .o_use_ext_auth(ext),
		.o_auth_tail_octets(oct), .o_lac_in_ram(logical_auth_counter), .o_tm_samples(tms),
		.o_parallel_mode(par), .o_priority_mode(pri), .o_vcid(vcid),
		.o_cfg_valid(cvalid));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task end_of_test;
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// one apb transfer; request held until pready seen at an edge
	task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb.penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			err_total++;
			end_of_test;
		end
		r = prdata;
		e = pslverr;
		apb <= '0;
	endtask : apb_xfer

	// expected derived outputs and config readback for straps s
	task cfg_check(input logic [5:0] s);
		logic [3:0] x_oct;
		logic [2:0] x_tm;
		x_oct = (s[5] && !s[4]) ? 4'h9 : 4'h0;
		x_tm = s[2] ? 3'h2 : 3'h5;
		chk(ext, s[5]);
		chk(oct, x_oct);
		chk(logical_auth_counter, !s[5] && s[4]);
		chk({tms, par, pri}, {x_tm, s[1:0]});
		apb_xfer(1'b0, 12'h004, 32'h0);
		chk({e, r[14:8], r[5:0]}, {1'b0, x_tm, x_oct, s});
	endtask : cfg_check

	initial forever #2 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test;
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{aus_sw, far_sw, stored, chan, start, tail_end, rom} = '0;
		{m_aus, m_far, m_chan, m_dec, pv} = '0;
		apb = '0;
		err_total = 0;
		samples_checked = 0;
		void'($urandom(47355));
		cfg = 6'($urandom);
		brd = {cfg, 1'b1};
		repeat (3) @(posedge clk);
		chk({aus_sel, far_sel, lchan, dec, cvalid, tms}, 32'h5);
		repeat (9) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		cfg_check(cfg);
		// every external/tail pairing, other straps random
		for (i = 0; i < 8; i++) begin
			cfg = {i[0], i[1], 4'($urandom)};
			brd <= {cfg, 1'b1};
			repeat (4) @(posedge clk);
			apb_xfer(1'b1, 12'h000, 32'h1);
			repeat (6) @(posedge clk);
			cfg_check(cfg);
		end
		// random core events, model checked every cycle
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			if (pv[13]) m_aus = !m_aus;
			if (pv[12]) m_far = !m_far;
			if (pv[11]) m_chan = pv[10:8];
			if (pv[7]) m_dec = 1'b1;
			else if (pv[6]) m_dec = 1'b0;
			m_vc = pv[5:0] ^ {5'h0, cfg[3]};
			pv = (i == 59) ? '0 : 14'($urandom);
			{aus_sw, far_sw, stored, chan, start, tail_end, rom} <= pv;
			@(negedge clk);
			chk({aus_sel, far_sel, lchan, dec, vcid},
				{m_aus, m_far, m_chan, m_dec, m_vc});
		end
		brd <= {cfg, 1'b0};
		repeat (6) @(posedge clk);
		chk(lflag, 1'b1);
		apb_xfer(1'b0, 12'h008, 32'h0);
		chk(r[9:0], {2'b10, !cfg[5] && cfg[4], 1'b1, m_dec, m_chan,
			m_far, m_aus});
		// unmapped read: error flag and zero data, checked apart
		apb_xfer(1'b0, 12'h00c, 32'h0);
		chk(e, 1'b1);
		chk(r, 32'h0);
		// write to a read-only register is ignored without error
		apb_xfer(1'b1, 12'h004, 32'hffff_ffff);
		chk(e, 1'b0);
		cfg_check(cfg);
		end_of_test;
	end
endmodule : tc_strap_status_tb
